/* shared/acrb_consts.svh */
// Register offsets, reset values and code constants of the ADC configuration bank.
`ifndef ACRB_CONSTS_SVH
`define ACRB_CONSTS_SVH
`define ACRB_ADDR_INPUT_PAIR 4'h0
`define ACRB_ADDR_BIAS 4'h1
`define ACRB_ADDR_REFMON 4'h2
`define ACRB_ADDR_GAINRATE 4'h3
`define ACRB_ADDR_OFC_LO 4'h4
`define ACRB_ADDR_OFC_MID 4'h5
`define ACRB_ADDR_OFC_HI 4'h6
`define ACRB_ADDR_FSC_LO 4'h7
`define ACRB_ADDR_FSC_MID 4'h8
`define ACRB_ADDR_FSC_HI 4'h9
`define ACRB_ADDR_REVMAG 4'hA
`define ACRB_ADDR_ROUTE 4'hB
`define ACRB_ADDR_PINFN 4'hC
`define ACRB_ADDR_PINDIR 4'hD
`define ACRB_ADDR_PINVAL 4'hE
`define ACRB_RST_INPUT_PAIR 8'h01
`define ACRB_RST_ZERO 8'h00
`define ACRB_RST_ROUTE 8'hFF
`define ACRB_UNMAPPED_READ 8'h00
`define ACRB_MON_NORMAL 3'h0
`define ACRB_MON_OFFSET 3'h1
`define ACRB_VREF_OFF 2'h0
`define ACRB_VREF_ON 2'h1
`define ACRB_GAIN_UNITY 3'h0
`define ACRB_RATE_TOP 4'h9
`define ACRB_BURN_OFF 2'h0
`define ACRB_MAG_OFF 3'h0
`define ACRB_REV_DEFAULT 4'h1
`endif

/* shared/acrb_pkg.sv */
// Types of the ADC configuration register bank.
package acrb_pkg;
  typedef enum logic [1:0] {ACRB_REF_IDLE, ACRB_REF_ON} acrb_ref_e;
  typedef struct packed {
    logic [7:0] inputPair;
    logic [7:0] biasMask;
    logic [6:0] refMon;
    logic [6:0] gainRate;
    logic [23:0] offsetCoeff;
    logic [23:0] fullscaleCoeff;
    logic [3:0] revMag;
    logic [7:0] route;
    logic [7:0] pinFunction;
    logic [7:0] pinDirection;
    logic [7:0] pinValue;
    logic [7:0] readData;
    acrb_ref_e refState;
    logic refPower;
    logic [2:0] effGain;
    logic [3:0] effRate;
    logic burnoutOn;
    logic readyOnPin;
    logic currentOn;
  } acrb_state_s;
endpackage : acrb_pkg

/* core/acrb_bank.sv */
// Configuration register bank of a multi-channel delta-sigma ADC.
`timescale 1ns/1ns
`include "acrb_consts.svh"
// Operation
// - Burnout level code 00 off, 01/10/11 give 0.5, 2, 10 uA.
// - Positive select code n routes input n; resets to input 0.
// - Negative select code n routes input n; resets to 001.
// - Monitor select or bias mask may override the chosen input pair.
// - Each bias mask bit biases the same-index input; all reset to zero.
// - Oscillator flag reads 0 for internal, 1 for external oscillator.
// - Reference control 00 keeps reference off (reset), 01 keeps it on.
// - Codes 10/11 power reference during conversion; shutdown or start low stops it.
// - Reference select picks pair 0, pair 1, onboard, or onboard onto pair 0.
// - Monitor codes map to normal, offset, gain, diode, refs, supplies.
// - Nonzero monitor code overrides input selects and bias mask.
// - Monitor codes 010 to 111 force unity gain; 000/001 use stored gain.
// - Returning to normal or offset restores the stored gain code.
// - Gain code sets gain of two to the code, 1 up to 128.
// - Rate codes 0000 to 1000 pick 5 to 1000 SPS; higher give 2000.
// - Offset coefficient spans addresses 04h low byte to 06h high byte.
// - Any gain code change reloads the full-scale coefficient with its trim.
// - Top four bits are read-only revision; bit 3 selects ready on data pin.
// - Excitation magnitude 000 off, else 50 to 1500 uA while the internal reference is powered.
module acrb_bank #(
  parameter int INPUTS = 8,
  parameter logic [3:0] REVISION = `ACRB_REV_DEFAULT, // Arbitrary value.
  parameter logic [191:0] FSC_TRIM = {8{24'h400000}}
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic externalOscillator,
  input wire logic conversionActive,
  input wire logic shutdownOpcode,
  input wire logic startPin,
  output logic [2:0] positiveInput,
  output logic [2:0] negativeInput,
  output logic [7:0] biasApplied,
  output logic [2:0] monitorSelect,
  output logic [1:0] referenceSelect,
  output logic internalReferenceOn,
  output logic [1:0] burnoutLevel,
  output logic burnoutOn,
  output logic [2:0] effectiveGain,
  output logic [3:0] effectiveRate,
  output logic [23:0] offsetCoefficient,
  output logic [23:0] fullscaleCoefficient,
  output logic readyOnOutputPin,
  output logic [2:0] excitationMagnitude,
  output logic excitationOn,
  output logic [7:0] sourceRoute,
  output logic [7:0] pinFunction,
  output logic [7:0] pinDirection,
  output logic [7:0] pinValue
);
  localparam logic [7:0] IMPL_MASK = (INPUTS >= 8) ? 8'hFF : 8'h0F;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [23:0] acrb_trim(input logic [2:0] gain);
    acrb_trim = FSC_TRIM[gain*24 +: 24];
  endfunction : acrb_trim

  function automatic logic acrb_forces_unity(input logic [2:0] mon);
    acrb_forces_unity = (mon != `ACRB_MON_NORMAL) && (mon != `ACRB_MON_OFFSET);
  endfunction : acrb_forces_unity

  acrb_pkg::acrb_state_s s;
  acrb_pkg::acrb_state_s next_s;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [2:0] newGain;
    logic [2:0] mon;
    newGain = s.gainRate[6:4];
    mon = s.refMon[2:0];
    next_s = s;
    // Register writes.
    if (regWrite) begin
      case (regAddr)
        `ACRB_ADDR_INPUT_PAIR: next_s.inputPair = regWriteData;
        `ACRB_ADDR_BIAS: next_s.biasMask = regWriteData & IMPL_MASK;
        `ACRB_ADDR_REFMON: next_s.refMon = regWriteData[6:0];
        `ACRB_ADDR_GAINRATE: begin
          // Bit 7 is held at zero; the host is expected to write it as zero.
          next_s.gainRate = regWriteData[6:0];
          newGain = regWriteData[6:4];
        end
        `ACRB_ADDR_OFC_LO: next_s.offsetCoeff[7:0] = regWriteData;
        `ACRB_ADDR_OFC_MID: next_s.offsetCoeff[15:8] = regWriteData;
        `ACRB_ADDR_OFC_HI: next_s.offsetCoeff[23:16] = regWriteData;
        `ACRB_ADDR_FSC_LO: next_s.fullscaleCoeff[7:0] = regWriteData;
        `ACRB_ADDR_FSC_MID: next_s.fullscaleCoeff[15:8] = regWriteData;
        `ACRB_ADDR_FSC_HI: next_s.fullscaleCoeff[23:16] = regWriteData;
        `ACRB_ADDR_REVMAG: next_s.revMag = regWriteData[3:0];
        `ACRB_ADDR_ROUTE: next_s.route = regWriteData;
        `ACRB_ADDR_PINFN: next_s.pinFunction = regWriteData & IMPL_MASK;
        `ACRB_ADDR_PINDIR: next_s.pinDirection = regWriteData & IMPL_MASK;
        `ACRB_ADDR_PINVAL: next_s.pinValue = regWriteData & IMPL_MASK;
        default: ;
      endcase
    end
    // A new gain code brings its factory trim with it, overriding any write.
    if (newGain != s.gainRate[6:4]) begin
      next_s.fullscaleCoeff = acrb_trim(newGain);
    end
    // Read data stands only in the cycle after the strobe.
    next_s.readData = `ACRB_UNMAPPED_READ;
    if (regRead) begin
      case (regAddr)
        `ACRB_ADDR_INPUT_PAIR: next_s.readData = s.inputPair;
        `ACRB_ADDR_BIAS: next_s.readData = s.biasMask;
        `ACRB_ADDR_REFMON: next_s.readData = {externalOscillator, s.refMon};
        `ACRB_ADDR_GAINRATE: next_s.readData = {1'b0, s.gainRate};
        `ACRB_ADDR_OFC_LO: next_s.readData = s.offsetCoeff[7:0];
        `ACRB_ADDR_OFC_MID: next_s.readData = s.offsetCoeff[15:8];
        `ACRB_ADDR_OFC_HI: next_s.readData = s.offsetCoeff[23:16];
        `ACRB_ADDR_FSC_LO: next_s.readData = s.fullscaleCoeff[7:0];
        `ACRB_ADDR_FSC_MID: next_s.readData = s.fullscaleCoeff[15:8];
        `ACRB_ADDR_FSC_HI: next_s.readData = s.fullscaleCoeff[23:16];
        `ACRB_ADDR_REVMAG: next_s.readData = {REVISION, s.revMag};
        `ACRB_ADDR_ROUTE: next_s.readData = s.route;
        `ACRB_ADDR_PINFN: next_s.readData = s.pinFunction;
        `ACRB_ADDR_PINDIR: next_s.readData = s.pinDirection;
        `ACRB_ADDR_PINVAL: next_s.readData = s.pinValue;
        default: next_s.readData = `ACRB_UNMAPPED_READ;
      endcase
    end
    // Reference power follows the control code; the automatic mode tracks conversions.
    case (s.refMon[6:5])
      `ACRB_VREF_OFF: begin
        next_s.refPower = 1'b0;
        next_s.refState = acrb_pkg::ACRB_REF_IDLE;
      end
      `ACRB_VREF_ON: begin
        next_s.refPower = 1'b1;
        next_s.refState = acrb_pkg::ACRB_REF_ON;
      end
      default: begin
        case (s.refState)
          acrb_pkg::ACRB_REF_IDLE: begin
            if (conversionActive && startPin && !shutdownOpcode) begin
              next_s.refState = acrb_pkg::ACRB_REF_ON;
            end
          end
          acrb_pkg::ACRB_REF_ON: begin
            if (shutdownOpcode || !startPin) begin
              next_s.refState = acrb_pkg::ACRB_REF_IDLE;
            end
          end
          default: next_s.refState = acrb_pkg::ACRB_REF_IDLE;
        endcase
        next_s.refPower = (next_s.refState == acrb_pkg::ACRB_REF_ON);
      end
    endcase
    // Derived controls, registered so that every output comes from a flip-flop.
    next_s.effGain = acrb_forces_unity(mon) ? `ACRB_GAIN_UNITY : s.gainRate[6:4];
    next_s.effRate = (s.gainRate[3:0] > `ACRB_RATE_TOP) ? `ACRB_RATE_TOP : s.gainRate[3:0];
    next_s.burnoutOn = (s.inputPair[7:6] != `ACRB_BURN_OFF);
    next_s.readyOnPin = s.revMag[3];
    next_s.currentOn = (s.revMag[2:0] != `ACRB_MAG_OFF) && s.refPower;
    if (!resetn) begin
      next_s = '0;
      next_s.inputPair = `ACRB_RST_INPUT_PAIR;
      next_s.route = `ACRB_RST_ROUTE;
      next_s.fullscaleCoeff = acrb_trim(`ACRB_GAIN_UNITY);
      next_s.refState = acrb_pkg::ACRB_REF_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // The analog mux applies the monitor override; these pass the stored selection and code.
  assign regReadData = s.readData;
  assign positiveInput = s.inputPair[5:3];
  assign negativeInput = s.inputPair[2:0];
  assign monitorSelect = s.refMon[2:0];
  assign referenceSelect = s.refMon[4:3];
  assign internalReferenceOn = s.refPower;
  assign burnoutLevel = s.inputPair[7:6];
  assign burnoutOn = s.burnoutOn;
  assign effectiveGain = s.effGain;
  assign effectiveRate = s.effRate;
  assign offsetCoefficient = s.offsetCoeff;
  assign fullscaleCoefficient = s.fullscaleCoeff;
  assign readyOnOutputPin = s.readyOnPin;
  assign excitationMagnitude = s.revMag[2:0];
  assign excitationOn = s.currentOn;
  assign sourceRoute = s.route;
  assign pinFunction = s.pinFunction;
  assign pinDirection = s.pinDirection;
  assign pinValue = s.pinValue;

  // Bias is suppressed while a system monitor owns the converter input.
  logic [7:0] biasReg;
  generate
    for (genvar i = 0; i < 8; i++) begin : g_bias
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          biasReg[i] <= 1'b0;
        end else begin
          biasReg[i] <= next_s.biasMask[i] && (next_s.refMon[2:0] == `ACRB_MON_NORMAL);
        end
      end
    end
  endgenerate
  assign biasApplied = biasReg;
endmodule : acrb_bank

/* test/acrb_bank_sva.sv */
// Port assertions of the ADC configuration register bank.
`timescale 1ns/1ns
module acrb_bank_sva (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  input wire logic externalOscillator,
  input wire logic [2:0] positiveInput,
  input wire logic [2:0] negativeInput,
  input wire logic [7:0] biasApplied,
  input wire logic [2:0] monitorSelect,
  input wire logic [1:0] burnoutLevel,
  input wire logic burnoutOn,
  input wire logic [2:0] effectiveGain,
  input wire logic [23:0] offsetCoefficient,
  input wire logic [2:0] excitationMagnitude,
  input wire logic excitationOn
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_read_refmon;
    regRead && regAddr == 4'h2;
  endsequence
  sequence s_monitor_forced;
    monitorSelect >= 3'h2;
  endsequence
  a_read_idle: assert property (!regRead |=> regReadData == 8'h00)
    else $error("read data not zero outside a read");
  a_osc_flag: assert property (s_read_refmon |=> regReadData[7] == $past(externalOscillator))
    else $error("oscillator flag wrong");
  a_gain_forced: assert property (s_monitor_forced |=> effectiveGain == 3'h0)
    else $error("gain not forced to unity");
  a_bias_gated: assert property (monitorSelect != 3'h0 && $past(monitorSelect) != 3'h0 |-> biasApplied == 8'h00)
    else $error("bias not gated by monitor");
  a_burn_flag: assert property (burnoutOn == ($past(burnoutLevel) != 2'h0))
    else $error("burnout enable wrong");
  a_excite_off: assert property (excitationMagnitude == 3'h0 && $past(excitationMagnitude) == 3'h0 |-> !excitationOn)
    else $error("excitation on at zero magnitude");
  a_input_pair: assert property (regWrite && regAddr == 4'h0 |=>
    positiveInput == $past(regWriteData[5:3]) && negativeInput == $past(regWriteData[2:0]))
    else $error("input pair not updated");
  a_offset_low: assert property (regWrite && regAddr == 4'h4 |=> offsetCoefficient[7:0] == $past(regWriteData))
    else $error("offset low byte not updated");
  a_offset_read: assert property (regRead && regAddr == 4'h6 |=> regReadData == $past(offsetCoefficient[23:16]))
    else $error("offset high byte read wrong");
  a_unmapped_read: assert property (regRead && regAddr == 4'hF |=> regReadData == 8'h00)
    else $error("unmapped read not zero");
endmodule : acrb_bank_sva
bind acrb_bank acrb_bank_sva i_acrb_bank_sva (.*);

/* test/acrb_host.sv */
// Host model that drives the register bus of the configuration bank.
`timescale 1ns/1ns
module acrb_host (
  input wire logic ref_clk,
  output logic [3:0] regAddr,
  output logic [7:0] regWriteData,
  output logic regWrite,
  output logic regRead,
  input wire logic [7:0] regReadData
);
  // Non-blocking like the tasks, so no signal mixes both kinds of assignment.
  initial begin
    regAddr <= 4'h0;
    regWriteData <= 8'h00;
    regWrite <= 1'b0;
    regRead <= 1'b0;
  end
  // Each call starts on a fresh edge, so a strobe is never set and cleared in one step.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWriteData <= (a == 4'h3) ? {1'b0, d[6:0]} : d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 d = regReadData;
  endtask : rd
endmodule : acrb_host

/* test/testbench.sv */
// Self-checking testbench of the ADC configuration register bank.
`timescale 1ns/1ns
`include "acrb_consts.svh"
module testbench;
  localparam logic [191:0] TRIM = {24'h777777, 24'h666666, 24'h555555, 24'h444444,
    24'h333333, 24'h222222, 24'h111111, 24'h400000};
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic externalOscillator = 1'b0;
  logic conversionActive = 1'b0;
  logic shutdownOpcode = 1'b0;
  logic startPin = 1'b0;
  logic [3:0] regAddr, effectiveRate;
  logic [7:0] regWriteData, regReadData, rd, biasApplied, sourceRoute, pinFunction, pinDirection, pinValue;
  logic regWrite, regRead, internalReferenceOn, burnoutOn, excitationOn, readyOnOutputPin;
  logic [2:0] positiveInput, negativeInput, monitorSelect, effectiveGain, excitationMagnitude;
  logic [1:0] burnoutLevel, referenceSelect;
  logic [23:0] offsetCoefficient, fullscaleCoefficient;
  logic [19:0] rows [16] = '{20'h0EAEA, 20'h15A5A, 20'h2FF7F, 20'h37C7C, 20'h41111, 20'h52222,
    20'h63333, 20'h74444, 20'h85555, 20'h96666, {4'hA, 8'hFF, `ACRB_REV_DEFAULT, 4'hF},
    20'hBC3C3, 20'hC0F0F, 20'hDF0F0, 20'hEAAAA, 20'hF5500};
  int num_errors = 0;
  int checked = 0;
  always #10 ref_clk = ~ref_clk;
  acrb_host i_acrb_host (.*);
  acrb_bank #(.FSC_TRIM(TRIM)) i_acrb_bank (.*);
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    i_acrb_host.rd(a, rd);
    chk("readback", rd, e);
  endtask : rdchk
  // Two edges cover outputs that trail their register by a cycle.
  task automatic wrw(input logic [3:0] a, input logic [7:0] d);
    i_acrb_host.wr(a, d);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : wrw
  task automatic results;
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      i_acrb_host.wr(rows[i][19:16], rows[i][15:8]);
      rdchk(rows[i][19:16], rows[i][7:0]);
    end
    chk("posIn", positiveInput, 3'h5);
    chk("negIn", negativeInput, 3'h2);
    chk("burn", {burnoutLevel, burnoutOn}, 3'h7);
    chk("offset", offsetCoefficient, 24'h332211);
    chk("ready", readyOnOutputPin, 1'b1);
    chk("gainMon", effectiveGain, 3'h0);
    chk("biasMon", biasApplied, 8'h00);
    chk("rate", effectiveRate, 4'h9);
    chk("exciteNoRef", excitationOn, 1'b0);
    chk("monSel", monitorSelect, 3'h7);
    chk("refSel", referenceSelect, 2'h3);
    chk("route", sourceRoute, 8'hC3);
    chk("pinFn", pinFunction, 8'h0F);
    chk("pinDir", pinDirection, 8'hF0);
    chk("pinVal", pinValue, 8'hAA);
    wrw(4'h2, 8'h01);
    chk("gainOffset", effectiveGain, 3'h7);
    chk("biasOffset", biasApplied, 8'h00);
    chk("monOffset", monitorSelect, 3'h1);
    wrw(4'h2, 8'h20);
    chk("bias", biasApplied, 8'h5A);
    chk("refOn", internalReferenceOn, 1'b1);
    chk("refSelPair0", referenceSelect, 2'h0);
    chk("excite", {excitationMagnitude, excitationOn}, 4'hF);
    wrw(4'h3, 8'h35);
    chk("gainRate", {effectiveGain, effectiveRate}, 7'h35);
    chk("fscReload", fullscaleCoefficient, TRIM[72 +: 24]);
    wrw(4'h2, 8'h50);
    chk("autoIdle", internalReferenceOn, 1'b0);
    chk("refSelOnboard", referenceSelect, 2'h2);
    @(posedge ref_clk);
    externalOscillator <= 1'b1;
    rdchk(4'h2, 8'hD0);
    @(posedge ref_clk);
    conversionActive <= 1'b1;
    startPin <= 1'b1;
    wrw(4'h0, 8'h01);
    chk("autoRun", internalReferenceOn, 1'b1);
    @(posedge ref_clk);
    startPin <= 1'b0;
    wrw(4'h0, 8'h01);
    chk("autoStartLow", internalReferenceOn, 1'b0);
    @(posedge ref_clk);
    startPin <= 1'b1;
    wrw(4'h0, 8'h01);
    chk("autoRestart", internalReferenceOn, 1'b1);
    // The shutdown must turn a running reference off, not merely keep an idle one idle.
    @(posedge ref_clk);
    shutdownOpcode <= 1'b1;
    wrw(4'h0, 8'h01);
    chk("autoShutdown", internalReferenceOn, 1'b0);
    @(posedge ref_clk);
    shutdownOpcode <= 1'b0;
    wrw(4'h2, 8'h00);
    chk("refOff", internalReferenceOn, 1'b0);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    rdchk(4'h0, `ACRB_RST_INPUT_PAIR);
    rdchk(4'h1, 8'h00);
    rdchk(4'h3, 8'h00);
    rdchk(4'hB, `ACRB_RST_ROUTE);
    chk("fscReset", fullscaleCoefficient, TRIM[23:0]);
    chk("offsetReset", offsetCoefficient, 24'h000000);
    chk("pinReset", pinValue, 8'h00);
    rdchk(4'h2, 8'h80);
    results();
  end
endmodule : testbench
